// >>> ctu_map.vh
`ifndef CTU_MAP_VH
`define CTU_MAP_VH
// Register offsets (byte addresses, word aligned)
`define CTU_ADDR_EN_CLR      8'h00
`define CTU_ADDR_EN_SET      8'h04
`define CTU_ADDR_CTRL        8'h08
`define CTU_ADDR_WRAP        8'h0C
`define CTU_ADDR_CMP         8'h10
`define CTU_ADDR_CMP_BUF     8'h14
`define CTU_ADDR_TRIG_SRC    8'h18
`define CTU_ADDR_TRIG_EDGE   8'h1C
`define CTU_ADDR_CMD_START   8'h20
`define CTU_ADDR_CMD_CAPTURE 8'h24
`define CTU_ADDR_CMD_RELOAD  8'h28
`define CTU_ADDR_CMD_STOP    8'h2C
`define CTU_ADDR_STATUS      8'h30
`define CTU_ADDR_COUNT       8'h34
// Control register fields
`define CTU_CTRL_MODE_HI     26
`define CTU_CTRL_MODE_LO     24
`define CTU_CTRL_ONESHOT     18
`define CTU_CTRL_DIR_HI      17
`define CTU_CTRL_DIR_LO      16
`define CTU_CTRL_PRE_HI      15
`define CTU_CTRL_PRE_LO      8
`define CTU_CTRL_SWAP        0
// Operating modes
`define CTU_MODE_TIMER       3'h0
`define CTU_MODE_CAPTURE     3'h2
// Direction modes
`define CTU_DIR_UP           2'h0
`define CTU_DIR_DOWN         2'h1
`define CTU_DIR_UPDN1        2'h2
`define CTU_DIR_UPDN2        2'h3
// Edge detection modes
`define CTU_EDGE_RISE        2'h0
`define CTU_EDGE_FALL        2'h1
`define CTU_EDGE_BOTH        2'h2
`define CTU_EDGE_LEVEL       2'h3
// Event indices within trigger registers
`define CTU_EV_RELOAD        0
`define CTU_EV_START         1
`define CTU_EV_STOP          2
`define CTU_EV_CAPTURE       3
`define CTU_EV_COUNT         4
`define CTU_EV_NUM           5
// Trigger source field width, edge field width
`define CTU_SRC_W            4
`define CTU_EDGE_W           2
// Reset values and load constants
`define CTU_CTRL_RST         32'h0000_0000
`define CTU_TRIG_SRC_RST     32'h0000_0000
`define CTU_TRIG_EDGE_RST    32'h0000_0300
`define CTU_UPDN_LOAD        32'h0000_0001
// Output pulse length in system clocks
`define CTU_PULSE_CYC        2'h2
`endif

// >>> ctu_counter_timer_capture.v
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "ctu_map.vh"
module ctu_counter_timer_capture #(
  parameter CNT_W = 32,
  parameter TRIG_N = 16
) (
  // Clock and reset
  input  wire              clk_i,
  input  wire              resetn_i,
  // Register port
  input  wire [7:0]        addr_i,
  input  wire [31:0]       wdata_i,
  input  wire              wr_i,
  input  wire              rd_i,
  output reg  [31:0]       rdata_o,
  // Trigger inputs
  input  wire [TRIG_N-1:0] trig_i,
  // Event outputs
  output wire              top_wrap_event_o,
  output wire              bottom_wrap_event_o,
  output wire              compare_hit_event_o,
  output wire              terminal_event_o,
  output wire              running_o
);

  ////////////////////////////////////////////////////////////////
  // Registers
  reg              enable_ff;
  reg [31:0]       ctrl_ff;
  reg [CNT_W-1:0]  wrap_ff;
  reg [CNT_W-1:0]  cmp_ff;
  reg [CNT_W-1:0]  cmp_buf_ff;
  reg [31:0]       trig_src_ff;
  reg [31:0]       trig_edge_ff;
  reg [CNT_W-1:0]  count_ff;
  reg              running_ff;
  reg              dir_down_ff;
  reg [7:0]        pre_cnt_ff;
  reg [TRIG_N-1:0] trig_prev_ff;
  reg [`CTU_EV_NUM-1:0] pend_ff;
  reg [1:0]        ov_cnt_ff;
  reg [1:0]        un_cnt_ff;
  reg [1:0]        cc_cnt_ff;
  reg              tc_ff;

  wire [2:0] mode    = ctrl_ff[`CTU_CTRL_MODE_HI:`CTU_CTRL_MODE_LO];
  wire [1:0] dir     = ctrl_ff[`CTU_CTRL_DIR_HI:`CTU_CTRL_DIR_LO];
  wire [7:0] pre     = ctrl_ff[`CTU_CTRL_PRE_HI:`CTU_CTRL_PRE_LO];
  wire       oneshot = ctrl_ff[`CTU_CTRL_ONESHOT];
  wire       swap_en = ctrl_ff[`CTU_CTRL_SWAP];
  wire       is_cap  = (mode == `CTU_MODE_CAPTURE);
  wire       is_tmr  = (mode == `CTU_MODE_TIMER);

  // Up/down load value, cut to the counter width so a narrow counter still
  // starts at one rather than taking a silently truncated wider constant
  localparam [31:0] UPDN_LOAD = `CTU_UPDN_LOAD;

  // Decode one word-aligned register write
  function wr_hit;
    input [7:0] a;
    input [7:0] cmp_addr;
    begin
      wr_hit = (a == cmp_addr);
    end
  endfunction

  wire wr_en_clr  = wr_i & wr_hit(addr_i, `CTU_ADDR_EN_CLR) & wdata_i[0];
  wire wr_en_set  = wr_i & wr_hit(addr_i, `CTU_ADDR_EN_SET) & wdata_i[0];
  wire cmd_start  = wr_i & wr_hit(addr_i, `CTU_ADDR_CMD_START) & wdata_i[0];
  wire cmd_cap    = wr_i & wr_hit(addr_i, `CTU_ADDR_CMD_CAPTURE) & wdata_i[0];
  wire cmd_reload = wr_i & wr_hit(addr_i, `CTU_ADDR_CMD_RELOAD) & wdata_i[0];
  wire cmd_stop   = wr_i & wr_hit(addr_i, `CTU_ADDR_CMD_STOP) & wdata_i[0];

  ////////////////////////////////////////////////////////////////
  // Trigger selection and edge detection per event
  wire [`CTU_EV_NUM-1:0] ev_det;
  wire [`CTU_EV_NUM-1:0] ev_sw;
  assign ev_sw = {1'b0, cmd_cap, cmd_stop, cmd_start, cmd_reload};

  genvar g;
  generate
    for (g = 0; g < `CTU_EV_NUM; g = g + 1) begin : g_ev
      // Source fields sit one nibble apart so all five events fit one word
      wire [`CTU_SRC_W-1:0]  sel  = trig_src_ff[g*`CTU_SRC_W +: `CTU_SRC_W];
      wire [`CTU_EDGE_W-1:0] emod = trig_edge_ff[g*2 +: `CTU_EDGE_W];
      wire                   cur  = trig_i[sel];
      wire                   old  = trig_prev_ff[sel];
      reg                    det;
      // Edge mode chooses which transitions count
      always @* begin
        case (emod)
          `CTU_EDGE_RISE: det = cur & ~old;
          `CTU_EDGE_FALL: det = ~cur & old;
          `CTU_EDGE_BOTH: det = cur ^ old;
          default:        det = cur;
        endcase
      end
      assign ev_det[g] = det;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Prescaler: one active count cycle every pre+1 clocks
  // Divider parks at zero while stopped, so the first period is full length
  wire pre_tick = (pre_cnt_ff == pre);
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre_cnt_ff <= 8'h00;
    end else if (!running_ff || pre_tick) begin
      pre_cnt_ff <= 8'h00;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 8'h01;
    end
  end

  // Count event qualified by the prescaler
  wire count_lvl = ev_det[`CTU_EV_COUNT];
  wire active    = pre_tick & count_lvl;

  ////////////////////////////////////////////////////////////////
  // Pending events: capture held until the next active cycle, reload until the count level
  wire [`CTU_EV_NUM-1:0] ev_in = ev_det | ev_sw;
  wire cap_edge_both = (trig_edge_ff[`CTU_EV_CAPTURE*2 +: `CTU_EDGE_W] == `CTU_EDGE_BOTH);
  wire reload_now = enable_ff & ~running_ff & (pend_ff[`CTU_EV_RELOAD] | ev_in[`CTU_EV_RELOAD])
                    & count_lvl;
  wire start_now  = enable_ff & ~running_ff & (pend_ff[`CTU_EV_START] | ev_in[`CTU_EV_START]);
  wire stop_now   = pend_ff[`CTU_EV_STOP] | ev_in[`CTU_EV_STOP];
  // Both-edge mode: a second edge cancels one already pending
  wire cap_req    = pend_ff[`CTU_EV_CAPTURE] ^ (cap_edge_both & ev_det[`CTU_EV_CAPTURE])
                    | (~cap_edge_both & ev_det[`CTU_EV_CAPTURE]) | cmd_cap;
  wire cap_now    = is_cap & running_ff & active & cap_req;

  // Pending flags: consume wins over set in the same cycle
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_ff <= {`CTU_EV_NUM{1'b0}};
    end else begin
      pend_ff[`CTU_EV_RELOAD] <= enable_ff & ~running_ff & (pend_ff[`CTU_EV_RELOAD] | ev_in[`CTU_EV_RELOAD])
                                 & ~count_lvl;
      // Start and stop act at once; only reload and capture wait
      pend_ff[`CTU_EV_START]  <= 1'b0;
      pend_ff[`CTU_EV_STOP]   <= 1'b0;
      // Edges fold into one flag; both-edge mode toggles for parity
      if (!is_cap || !enable_ff) begin
        pend_ff[`CTU_EV_CAPTURE] <= 1'b0;
      end else if (active && running_ff) begin
        pend_ff[`CTU_EV_CAPTURE] <= 1'b0;
      end else begin
        pend_ff[`CTU_EV_CAPTURE] <= cap_req;
      end
      pend_ff[`CTU_EV_COUNT] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Counter core
  wire at_zero  = (count_ff == {CNT_W{1'b0}});
  wire at_limit = (count_ff == wrap_ff);
  wire step     = running_ff & active;
  // Wraps come from the value being left, not the value reached
  wire ov_ev    = step & ~dir_down_ff & at_limit;
  wire un_ev    = step & dir_down_ff & at_zero;
  wire match_tm = is_tmr & step & (count_ff == cmp_ff);
  wire cc_ev    = is_cap ? cap_now : match_tm;
  reg  tc_ev;
  // Terminal event per direction mode
  always @* begin
    case (dir)
      `CTU_DIR_UP:    tc_ev = ov_ev;
      `CTU_DIR_UPDN2: tc_ev = ov_ev | un_ev;
      default:        tc_ev = un_ev;
    endcase
  end
  // One-shot halts on the wrap that ends a single period
  wire os_stop = oneshot & ((dir == `CTU_DIR_UP) ? ov_ev : un_ev);

  reg [CNT_W-1:0] nxt_count;
  reg             nxt_dir_down;
  // Next count and direction from the direction mode
  always @* begin
    nxt_count    = count_ff;
    nxt_dir_down = dir_down_ff;
    if (reload_now) begin
      case (dir)
        `CTU_DIR_UP: begin
          nxt_count    = {CNT_W{1'b0}};
          nxt_dir_down = 1'b0;
        end
        `CTU_DIR_DOWN: begin
          nxt_count    = wrap_ff;
          nxt_dir_down = 1'b1;
        end
        default: begin
          nxt_count    = UPDN_LOAD[CNT_W-1:0];
          nxt_dir_down = 1'b0;
        end
      endcase
    end else if (start_now) begin
      if (dir == `CTU_DIR_UP) begin
        nxt_dir_down = 1'b0;
      end else if (dir == `CTU_DIR_DOWN) begin
        nxt_dir_down = 1'b1;
      end
    end else if (step) begin
      case (dir)
        `CTU_DIR_UP:   nxt_count = at_limit ? {CNT_W{1'b0}} : count_ff + 1'b1;
        `CTU_DIR_DOWN: nxt_count = at_zero ? wrap_ff : count_ff - 1'b1;
        default: begin
          // Turn around at either end without stopping
          if (!dir_down_ff && at_limit) begin
            nxt_count    = count_ff - 1'b1;
            nxt_dir_down = 1'b1;
          end else if (dir_down_ff && at_zero) begin
            nxt_count    = count_ff + 1'b1;
            nxt_dir_down = 1'b0;
          end else begin
            nxt_count = dir_down_ff ? count_ff - 1'b1 : count_ff + 1'b1;
          end
        end
      endcase
    end
  end

  // Run state, count and direction
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      running_ff  <= 1'b0;
      count_ff    <= {CNT_W{1'b0}};
      dir_down_ff <= 1'b0;
    end else begin
      count_ff    <= nxt_count;
      dir_down_ff <= nxt_dir_down;
      // Stop outranks reload and start, so both together leave it halted
      if (!enable_ff || stop_now || os_stop) begin
        running_ff <= 1'b0;
      end else if (reload_now || start_now) begin
        running_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register writes and compare updates
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enable_ff    <= 1'b0;
      ctrl_ff      <= `CTU_CTRL_RST;
      wrap_ff      <= {CNT_W{1'b0}};
      cmp_ff       <= {CNT_W{1'b0}};
      cmp_buf_ff   <= {CNT_W{1'b0}};
      trig_src_ff  <= `CTU_TRIG_SRC_RST;
      trig_edge_ff <= `CTU_TRIG_EDGE_RST;
    end else begin
      // Clear wins when set and clear land together
      if (wr_en_clr) begin
        enable_ff <= 1'b0;
      end else if (wr_en_set) begin
        enable_ff <= 1'b1;
      end
      if (wr_i && wr_hit(addr_i, `CTU_ADDR_CTRL)) begin
        ctrl_ff <= wdata_i;
      end
      if (wr_i && wr_hit(addr_i, `CTU_ADDR_WRAP)) begin
        wrap_ff <= wdata_i[CNT_W-1:0];
      end
      if (wr_i && wr_hit(addr_i, `CTU_ADDR_TRIG_SRC)) begin
        trig_src_ff <= wdata_i;
      end
      if (wr_i && wr_hit(addr_i, `CTU_ADDR_TRIG_EDGE)) begin
        trig_edge_ff <= wdata_i;
      end
      // Hardware update beats a software write in the same cycle
      if (cap_now) begin
        cmp_ff     <= count_ff;
        cmp_buf_ff <= cmp_ff;
      end else if (match_tm && swap_en) begin
        cmp_ff     <= cmp_buf_ff;
        cmp_buf_ff <= cmp_ff;
      end else begin
        if (wr_i && wr_hit(addr_i, `CTU_ADDR_CMP)) begin
          cmp_ff <= wdata_i[CNT_W-1:0];
        end
        if (wr_i && wr_hit(addr_i, `CTU_ADDR_CMP_BUF)) begin
          cmp_buf_ff <= wdata_i[CNT_W-1:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Trigger history, two-clock wrap and compare pulses, one-clock terminal
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trig_prev_ff <= {TRIG_N{1'b0}};
      ov_cnt_ff    <= 2'h0;
      un_cnt_ff    <= 2'h0;
      cc_cnt_ff    <= 2'h0;
      tc_ff        <= 1'b0;
    end else begin
      trig_prev_ff <= trig_i;
      // A new event restarts a pulse, so events up to two clocks apart merge
      ov_cnt_ff    <= ov_ev ? `CTU_PULSE_CYC : (ov_cnt_ff - {1'b0, |ov_cnt_ff});
      un_cnt_ff    <= un_ev ? `CTU_PULSE_CYC : (un_cnt_ff - {1'b0, |un_cnt_ff});
      cc_cnt_ff    <= cc_ev ? `CTU_PULSE_CYC : (cc_cnt_ff - {1'b0, |cc_cnt_ff});
      // Terminal stays a single-cycle pulse
      tc_ff        <= tc_ev;
    end
  end

  assign top_wrap_event_o    = |ov_cnt_ff;
  assign bottom_wrap_event_o = |un_cnt_ff;
  assign compare_hit_event_o = |cc_cnt_ff;
  assign terminal_event_o    = tc_ff;
  assign running_o           = running_ff;

  ////////////////////////////////////////////////////////////////
  // Read port: data one cycle after the strobe
  // Idle cycles return zero so a stale word is never taken for an answer
  reg [31:0] nxt_rdata;
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (addr_i)
      `CTU_ADDR_EN_SET,
      `CTU_ADDR_EN_CLR:    nxt_rdata = {31'h0, enable_ff};
      `CTU_ADDR_CTRL:      nxt_rdata = ctrl_ff;
      `CTU_ADDR_WRAP:      nxt_rdata[CNT_W-1:0] = wrap_ff;
      `CTU_ADDR_CMP:       nxt_rdata[CNT_W-1:0] = cmp_ff;
      `CTU_ADDR_CMP_BUF:   nxt_rdata[CNT_W-1:0] = cmp_buf_ff;
      `CTU_ADDR_TRIG_SRC:  nxt_rdata = trig_src_ff;
      `CTU_ADDR_TRIG_EDGE: nxt_rdata = trig_edge_ff;
      `CTU_ADDR_STATUS:    nxt_rdata = {30'h0, dir_down_ff, running_ff};
      `CTU_ADDR_COUNT:     nxt_rdata[CNT_W-1:0] = count_ff;
      default:             nxt_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= nxt_rdata;
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

endmodule // ctu_counter_timer_capture

// >>> ctu_props.sv
`timescale 1ns/10ps
`include "ctu_map.vh"
module ctu_props (
  // Clock and reset
  input wire        clk_i,
  input wire        resetn_i,
  // Register port
  input wire [7:0]  addr_i,
  input wire [31:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [31:0] rdata_o,
  // Event outputs
  input wire        top_wrap_event_o,
  input wire        bottom_wrap_event_o,
  input wire        compare_hit_event_o,
  input wire        terminal_event_o,
  input wire        running_o
);
  // Single clock domain, reset disables all checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
////////////////////////////////////////
  // Read data idles at zero so a stale value cannot be taken for an answer
  AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data not zero outside read");
  // Event pulses are exactly two cycles
  AST_TOP_TWO: assert property ($rose(top_wrap_event_o) |=> top_wrap_event_o ##1 !top_wrap_event_o)
    else $error("top wrap pulse length wrong");
  AST_BOT_TWO: assert property ($rose(bottom_wrap_event_o) |=> bottom_wrap_event_o ##1 !bottom_wrap_event_o)
    else $error("bottom wrap pulse length wrong");
  AST_HIT_TWO: assert property ($rose(compare_hit_event_o) |=> compare_hit_event_o ##1 !compare_hit_event_o)
    else $error("compare hit pulse length wrong");
  // Terminal comes only with a wrap, one cycle long
  AST_TERM_CAUSE: assert property (terminal_event_o |-> $rose(top_wrap_event_o) || $rose(bottom_wrap_event_o))
    else $error("terminal without wrap");
  AST_TERM_ONE: assert property (terminal_event_o |=> !terminal_event_o)
    else $error("terminal longer than one cycle");
  // Counter cannot leave both ends at once
  AST_WRAP_EXCL: assert property (!($rose(top_wrap_event_o) && $rose(bottom_wrap_event_o)))
    else $error("both wraps start together");
  // Stop command halts the channel within a few cycles
  AST_STOP_HALT: assert property (wr_i && addr_i == `CTU_ADDR_CMD_STOP && wdata_i[0] |-> ##[1:3] !running_o)
    else $error("stop not honoured");
  // A top wrap only follows a step taken while running
  AST_RUN_STEP: assert property ($rose(top_wrap_event_o) |-> $past(running_o) || $past(running_o, 2))
    else $error("top wrap while stopped");
endmodule // ctu_props

bind ctu_counter_timer_capture ctu_props u_props (
  .clk_i               (clk_i),
  .resetn_i            (resetn_i),
  .addr_i              (addr_i),
  .wdata_i             (wdata_i),
  .wr_i                (wr_i),
  .rd_i                (rd_i),
  .rdata_o             (rdata_o),
  .top_wrap_event_o    (top_wrap_event_o),
  .bottom_wrap_event_o (bottom_wrap_event_o),
  .compare_hit_event_o (compare_hit_event_o),
  .terminal_event_o    (terminal_event_o),
  .running_o           (running_o)
);

// >>> testbench.sv
`timescale 1ns/10ps
`include "ctu_map.vh"
module testbench;
  reg         clk_i    = 1'b0;
  reg         resetn_i = 1'b0;
  reg  [7:0]  addr_i   = 8'h00;
  reg  [31:0] wdata_i  = 32'h0000_0000;
  reg         wr_i     = 1'b0;
  reg         rd_i     = 1'b0;
  reg  [15:0] trig_i   = 16'h0000;
  wire [31:0] rdata_o;
  wire [3:0]  evs;
  wire        run_o;
  integer     num_errors = 0;
  integer     n_checks   = 0;
  integer     per;
  integer     i;
  reg  [31:0] v;
  reg  [31:0] c1;
  reg  [31:0] tab [0:4];
  integer     xp  [0:4];
  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;
////////////////////////////////////////
  ctu_counter_timer_capture DUT (
    .clk_i               (clk_i),
    .resetn_i            (resetn_i),
    .addr_i              (addr_i),
    .wdata_i             (wdata_i),
    .wr_i                (wr_i),
    .rd_i                (rd_i),
    .rdata_o             (rdata_o),
    .trig_i              (trig_i),
    .top_wrap_event_o    (evs[0]),
    .bottom_wrap_event_o (evs[2]),
    .compare_hit_event_o (evs[1]),
    .terminal_event_o    (evs[3]),
    .running_o           (run_o)
  );
////////////////////////////////////////
  // Register port accesses
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
    end
  endtask
  // Data stands only in the cycle after the strobe
  task rd(input [7:0] a);
    begin
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
    end
  endtask
  task chk(input [63:0] nm, input [31:0] s, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        num_errors = num_errors + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // Cycles until event w is high; bounded so a dead counter cannot hang
  task gap(input integer w, output integer n);
    begin
      n = 0;
      do begin
        @(posedge clk_i);
        n = n + 1;
        if (n > 400) begin
          num_errors = num_errors + 1;
          test_done;
        end
      end while (evs[w] !== 1'b1);
    end
  endtask
  // Channel off while reconfiguring, then back on
  task cfg(input [31:0] c, input [31:0] w);
    begin
      wr(`CTU_ADDR_CMD_STOP, 32'h1);
      wr(`CTU_ADDR_EN_CLR, 32'h1);
      wr(`CTU_ADDR_CTRL, c);
      wr(`CTU_ADDR_WRAP, w);
      wr(`CTU_ADDR_EN_SET, 32'h1);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
////////////////////////////////////////
  // Main sequence
  initial begin
    tab[0] = 32'h0000_0000; xp[0] = 5;
    tab[1] = 32'h0001_0000; xp[1] = 5;
    tab[2] = 32'h0002_0000; xp[2] = 8;
    tab[3] = 32'h0003_0000; xp[3] = 4;
    tab[4] = 32'h0000_0100; xp[4] = 10;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    // Reset values and field storage
    rd(`CTU_ADDR_CTRL);      chk("ctrl", v, 32'h0000_0000);
    rd(`CTU_ADDR_TRIG_EDGE); chk("edge", v, 32'h0000_0300);
    rd(`CTU_ADDR_TRIG_SRC);  chk("src", v, 32'h0000_0000);
    rd(8'h3C);               chk("unmap", v, 32'h0000_0000);
    wr(`CTU_ADDR_WRAP, 32'hFFFF_FFFF);
    rd(`CTU_ADDR_WRAP);      chk("wrap", v, 32'hFFFF_FFFF);
    wr(`CTU_ADDR_CTRL, 32'h0207_FF01);
    rd(`CTU_ADDR_CTRL);      chk("ctrlf", v, 32'h0207_FF01);
    $display("test registers done");
    // Separate inputs per event; count event is a steady level on input 0
    wr(`CTU_ADDR_TRIG_SRC, 32'h0000_4321);
    trig_i[0] <= 1'b1;
    // Terminal spacing per direction and prescale
    for (i = 0; i < 5; i = i + 1) begin
      cfg(tab[i], 32'h4);
      wr(`CTU_ADDR_CMD_RELOAD, 32'h1);
      gap(3, per);
      gap(3, per);
      chk("period", per, xp[i]);
      if (i != 3) chk("wraps", {evs[0], evs[2]}, (i == 1 || i == 2) ? 2'b01 : 2'b10);
    end
    $display("test directions done");
    // Down one-shot stops itself after underflow
    cfg(32'h0005_0000, 32'h4);
    wr(`CTU_ADDR_CMD_RELOAD, 32'h1);
    gap(2, per);
    repeat (4) @(posedge clk_i);
    rd(`CTU_ADDR_STATUS); chk("oneshot", v, 32'h2);
    $display("test one-shot done");
    // Stop freezes the count, start resumes it
    cfg(32'h0, 32'h4);
    wr(`CTU_ADDR_CMD_RELOAD, 32'h1);
    repeat (3) @(posedge clk_i);
    wr(`CTU_ADDR_CMD_STOP, 32'h1);
    rd(`CTU_ADDR_COUNT);
    c1 = v;
    chk("runoff", run_o, 1'b0);
    repeat (5) @(posedge clk_i);
    rd(`CTU_ADDR_COUNT);  chk("frozen", v, c1);
    rd(`CTU_ADDR_STATUS); chk("stopped", v, 32'h0);
    wr(`CTU_ADDR_CMD_START, 32'h1);
    rd(`CTU_ADDR_STATUS); chk("started", v, 32'h1);
    chk("runon", run_o, 1'b1);
    $display("test stop start done");
    // Capture by command, then by rising edge on input 4
    cfg(32'h0200_0000, 32'hFF);
    wr(`CTU_ADDR_CMP, 32'h55);
    wr(`CTU_ADDR_CMD_RELOAD, 32'h1);
    repeat (6) @(posedge clk_i);
    wr(`CTU_ADDR_CMD_CAPTURE, 32'h1);
    gap(1, per);
    rd(`CTU_ADDR_CMP_BUF); chk("buf1", v, 32'h55);
    rd(`CTU_ADDR_CMP);
    c1 = v;
    trig_i[4] <= 1'b1;
    gap(1, per);
    chk("hitlat", per < 4, 1'b1);
    rd(`CTU_ADDR_CMP_BUF); chk("buf2", v, c1);
    trig_i[4] <= 1'b0;
    $display("test capture done");
    // Auto-swap on compare match; slow prescale leaves time to stop
    cfg(32'h0000_0701, 32'h4);
    wr(`CTU_ADDR_CMP, 32'h2);
    wr(`CTU_ADDR_CMP_BUF, 32'h0);
    wr(`CTU_ADDR_CMD_RELOAD, 32'h1);
    gap(1, per);
    wr(`CTU_ADDR_CMD_STOP, 32'h1);
    rd(`CTU_ADDR_CMP);     chk("swapc", v, 32'h0);
    rd(`CTU_ADDR_CMP_BUF); chk("swapb", v, 32'h2);
    $display("test swap done");
    // Both-edge capture: two edges before one active cycle cancel, one edge captures
    cfg(32'h0200_0700, 32'h1);
    wr(`CTU_ADDR_TRIG_EDGE, 32'h0000_0380);
    wr(`CTU_ADDR_CMP, 32'h77);
    wr(`CTU_ADDR_CMD_RELOAD, 32'h1);
    gap(0, per);
    trig_i[4] <= 1'b1;
    @(posedge clk_i);
    trig_i[4] <= 1'b0;
    repeat (12) @(posedge clk_i);
    rd(`CTU_ADDR_CMP); chk("even", v, 32'h77);
    trig_i[4] <= 1'b1;
    gap(1, per);
    rd(`CTU_ADDR_CMP_BUF); chk("odd", v, 32'h77);
    $display("test both edges done");
    test_done;
  end
endmodule // testbench
